/* design/ddc_link_pkg.sv */
// shared constants and types for the decimating serial link transmitter
package ddc_link_pkg;
	localparam int LANES_MAX = 16;
	localparam int LANE_CNT_W = 5;
	localparam int SAMPLE_W = 12;
	localparam int WORD_W = 16;
	localparam int ACC_W = 18;
	localparam int MODE_W = 4;
	// mode field layout: bit 3 picks the line coding, bits 2:0 the decimation
	localparam int MODE_CODING_BIT = 3;
	localparam logic [2:0] DEC_BYPASS = 3'h0;
	localparam logic [2:0] DEC_BY4 = 3'h1;
	localparam logic [2:0] DEC_BY8 = 3'h2;
	localparam logic [2:0] DEC_BY16 = 3'h3;
	localparam logic [2:0] DEC_BY32 = 3'h4;
	localparam int WORD_PAD = WORD_W - SAMPLE_W;
	// control characters
	localparam logic [7:0] CHAR_COMMA = 8'hBC;
	localparam logic [7:0] CHAR_MF_START = 8'h1C;
	localparam logic [7:0] CHAR_MF_END = 8'h7C;
	localparam logic [7:0] CHAR_CFG_START = 8'h9C;
	// link framing
	localparam int MF_OCTETS = 32;
	localparam int ILAS_MF = 4;
	localparam int BLOCK_OCTETS = 8;
	localparam int MB_BLOCKS = 32;
	localparam int EMB_MB = 4;
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_IDLE = 2'h0;
	localparam int SUBCLASS = 1;
	localparam logic [15:0] ZERO16 = 16'h0000;
	typedef enum logic [2:0] {
		LINK_CGS,
		LINK_WAIT_MF,
		LINK_ILAS,
		LINK_DATA,
		LINK_BLOCKS
	} link_state_t;
endpackage

/* design/ddc_to_serial_link_tx.sv */
// decimating front end, gain boost and lane framing of the serial link transmitter
`timescale 1ns/100ps
`default_nettype none
module ddc_to_serial_link_tx
	import ddc_link_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ddc_link_pkg::MODE_W-1:0] linkModeSelect,
	input wire logic gainBoost,
	input wire logic [ddc_link_pkg::LANE_CNT_W-1:0] laneCount,
	input wire logic fecEnable,
	input wire logic handshakeUsePair,
	input wire logic handshakeSingleEndedIn,
	input wire logic timestampPairPos,
	input wire logic timestampPairNeg,
	input wire logic sysrefIn,
	input wire logic signed [ddc_link_pkg::SAMPLE_W-1:0] sampleIn,
	output logic [8*ddc_link_pkg::LANES_MAX-1:0] laneOctets,
	output logic [ddc_link_pkg::LANES_MAX-1:0] laneIsControl,
	output logic [ddc_link_pkg::LANES_MAX-1:0] laneActive,
	output logic [1:0] blockHeader,
	output logic blockStart,
	output logic frameBoundary,
	output logic ncoSyncPulse,
	output logic fecActive,
	output logic complexOutput,
	output logic linkUp
);
	import ddc_link_pkg::*;

	// saturating doubling keeps a boosted full-scale sample from wrapping
	function automatic logic [WORD_W-1:0] boostSat(input logic [WORD_W-1:0] w, input logic boost);
		logic [WORD_W-1:0] r;
		r = w;
		if (boost) begin
			if (w[WORD_W-1] != w[WORD_W-2]) begin
				r = w[WORD_W-1] ? {1'b1, {(WORD_W-1){1'b0}}} : {1'b0, {(WORD_W-1){1'b1}}};
			end else begin
				r = {w[WORD_W-2:0], 1'b0};
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] decShift(input logic [2:0] dec);
		logic [2:0] s;
		case (dec)
			DEC_BY4: s = 3'h2;
			DEC_BY8: s = 3'h3;
			DEC_BY16: s = 3'h4;
			DEC_BY32: s = 3'h5;
			default: s = 3'h0;
		endcase
		return s;
	endfunction

	// pin synchronizers; the first stage feeds only the second
	logic [1:0] seSync_q;
	logic [1:0] posSync_q;
	logic [1:0] negSync_q;
	logic [1:0] refSync_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seSync_q <= 2'h3;
			posSync_q <= 2'h3;
			negSync_q <= 2'h0;
			refSync_q <= 2'h0;
		end else begin
			seSync_q <= {seSync_q[0], handshakeSingleEndedIn};
			posSync_q <= {posSync_q[0], timestampPairPos};
			negSync_q <= {negSync_q[0], timestampPairNeg};
			refSync_q <= {refSync_q[0], sysrefIn};
		end
	end

	logic handshakeLevel;
	logic mode66;
	logic [2:0] decSel;
	assign handshakeLevel = handshakeUsePair ? (posSync_q[1] & ~negSync_q[1]) : seSync_q[1];
	assign mode66 = linkModeSelect[MODE_CODING_BIT];
	assign decSel = linkModeSelect[2:0];

	// edge detection state on synchronized levels
	logic hsPrev_q, hsPrev_d;
	logic refPrev_q, refPrev_d;
	logic ncoSync_q, ncoSync_d;
	logic sysrefEdge;
	assign sysrefEdge = refSync_q[1] & ~refPrev_q;
	always_comb begin
		hsPrev_d = handshakeLevel;
		refPrev_d = refSync_q[1];
		ncoSync_d = mode66 & hsPrev_q & ~handshakeLevel;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hsPrev_q <= 1'b1;
			refPrev_q <= 1'b0;
			ncoSync_q <= 1'b0;
		end else begin
			hsPrev_q <= hsPrev_d;
			refPrev_q <= refPrev_d;
			ncoSync_q <= ncoSync_d;
		end
	end

	// decimator: fs/4 mixer, integrate and dump over the ratio, I then Q words
	logic [4:0] phase_q, phase_d;
	logic signed [ACC_W-1:0] accI_q, accI_d, accQ_q, accQ_d;
	logic [WORD_W-1:0] word_q, word_d;
	logic [WORD_W-1:0] pendQ_q, pendQ_d;
	logic wordValid_q, wordValid_d;
	logic pendValid_q, pendValid_d;
	logic signed [ACC_W-1:0] mixI, mixQ, sumI, sumQ, avgI, avgQ;
	logic [4:0] lastPhase;
	logic [2:0] shiftBy;
	always_comb begin
		shiftBy = decShift(decSel);
		lastPhase = 5'((1 << shiftBy) - 1);
		mixI = '0;
		mixQ = '0;
		case (phase_q[1:0])
			2'h0: mixI = ACC_W'(sampleIn);
			2'h1: mixQ = -ACC_W'(sampleIn);
			2'h2: mixI = -ACC_W'(sampleIn);
			default: mixQ = ACC_W'(sampleIn);
		endcase
		sumI = accI_q + mixI;
		sumQ = accQ_q + mixQ;
		avgI = sumI >>> shiftBy;
		avgQ = sumQ >>> shiftBy;
		phase_d = phase_q + 5'h1;
		accI_d = sumI;
		accQ_d = sumQ;
		word_d = word_q;
		wordValid_d = 1'b0;
		pendQ_d = pendQ_q;
		pendValid_d = 1'b0;
		if (decSel == DEC_BYPASS || decSel > DEC_BY32) begin
			// real undecimated samples, one word per clock
			phase_d = 5'h0;
			accI_d = '0;
			accQ_d = '0;
			word_d = boostSat({sampleIn, {WORD_PAD{1'b0}}}, gainBoost);
			wordValid_d = 1'b1;
		end else if (pendValid_q) begin
			word_d = pendQ_q;
			wordValid_d = 1'b1;
		end
		if (decSel != DEC_BYPASS && decSel <= DEC_BY32 && phase_q >= lastPhase) begin
			phase_d = 5'h0;
			accI_d = '0;
			accQ_d = '0;
			word_d = boostSat({avgI[SAMPLE_W-1:0], {WORD_PAD{1'b0}}}, gainBoost);
			wordValid_d = 1'b1;
			pendQ_d = boostSat({avgQ[SAMPLE_W-1:0], {WORD_PAD{1'b0}}}, gainBoost);
			pendValid_d = 1'b1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_q <= 5'h0;
			accI_q <= '0;
			accQ_q <= '0;
			word_q <= ZERO16;
			pendQ_q <= ZERO16;
			wordValid_q <= 1'b0;
			pendValid_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			accI_q <= accI_d;
			accQ_q <= accQ_d;
			word_q <= word_d;
			pendQ_q <= pendQ_d;
			wordValid_q <= wordValid_d;
			pendValid_q <= pendValid_d;
		end
	end

	// staging: each word splits into two octets placed round-robin over the active lanes
	logic [7:0] stage_q [LANES_MAX];
	logic [7:0] stage_d [LANES_MAX];
	logic [3:0] wrPtr_q, wrPtr_d;
	logic [3:0] ptrNext;
	logic [3:0] basePtr;
	logic [LANE_CNT_W-1:0] lanesUsed;
	always_comb begin
		lanesUsed = (laneCount == '0) ? LANE_CNT_W'(1) :
			(laneCount > LANE_CNT_W'(LANES_MAX)) ? LANE_CNT_W'(LANES_MAX) : laneCount;
		stage_d = stage_q;
		wrPtr_d = wrPtr_q;
		// a pointer left beyond a shrunk lane count restarts at lane 0, keeping the octet pairs aligned
		basePtr = (LANE_CNT_W'(wrPtr_q) >= lanesUsed) ? 4'h0 : wrPtr_q;
		ptrNext = basePtr + 4'h1;
		if (LANE_CNT_W'(ptrNext) >= lanesUsed) begin
			ptrNext = 4'h0;
		end
		if (wordValid_q) begin
			stage_d[basePtr] = word_q[15:8];
			stage_d[ptrNext] = word_q[7:0];
			wrPtr_d = ptrNext + 4'h1;
			if (LANE_CNT_W'(wrPtr_d) >= lanesUsed || wrPtr_d == 4'h0) begin
				wrPtr_d = 4'h0;
			end
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < LANES_MAX; i++) begin
				stage_q[i] <= 8'h00;
			end
			wrPtr_q <= 4'h0;
		end else begin
			stage_q <= stage_d;
			wrPtr_q <= wrPtr_d;
		end
	end

	// link framing: one octet per lane per device clock
	link_state_t state_q, state_d;
	logic [4:0] mfCnt_q, mfCnt_d;
	logic [1:0] ilasCnt_q, ilasCnt_d;
	logic [2:0] blkOct_q, blkOct_d;
	logic [4:0] mbCnt_q, mbCnt_d;
	logic [1:0] embCnt_q, embCnt_d;
	logic [8*LANES_MAX-1:0] octets_d;
	logic [LANES_MAX-1:0] isCtl_d, active_d;
	logic [1:0] header_d;
	logic blockStart_d, boundary_d;
	logic mfEdge;
	logic [7:0] ilasOct;
	logic ilasCtl;
	always_comb begin
		mfEdge = (mfCnt_q == 5'(MF_OCTETS - 1));
		state_d = state_q;
		mfCnt_d = mfCnt_q + 5'h1;
		ilasCnt_d = ilasCnt_q;
		blkOct_d = blkOct_q + 3'h1;
		mbCnt_d = mbCnt_q;
		embCnt_d = embCnt_q;
		if (blkOct_q == 3'(BLOCK_OCTETS - 1)) begin
			mbCnt_d = mbCnt_q + 5'h1;
			if (mbCnt_q == 5'(MB_BLOCKS - 1)) begin
				embCnt_d = embCnt_q + 2'h1;
			end
		end
		if (sysrefEdge) begin
			// subclass 1 deterministic counter reset
			mfCnt_d = 5'h0;
			blkOct_d = 3'h0;
			mbCnt_d = 5'h0;
			embCnt_d = 2'h0;
		end
		ilasOct = {3'h0, mfCnt_q};
		ilasCtl = 1'b0;
		if (mfCnt_q == 5'h0) begin
			ilasOct = CHAR_MF_START;
			ilasCtl = 1'b1;
		end else if (mfEdge) begin
			ilasOct = CHAR_MF_END;
			ilasCtl = 1'b1;
		end else if (ilasCnt_q == 2'h1 && mfCnt_q == 5'h1) begin
			ilasOct = CHAR_CFG_START;
			ilasCtl = 1'b1;
		end
		// 64b/66b framing ignores the handshake; in that mode its falling edge only fires ncoSyncPulse
		if (mode66) begin
			state_d = LINK_BLOCKS;
		end else begin
			case (state_q)
				LINK_CGS: begin
					if (handshakeLevel) begin
						state_d = LINK_WAIT_MF;
					end
				end
				LINK_WAIT_MF: begin
					if (mfEdge) begin
						state_d = LINK_ILAS;
						ilasCnt_d = 2'h0;
					end
				end
				LINK_ILAS: begin
					if (mfEdge) begin
						ilasCnt_d = ilasCnt_q + 2'h1;
						if (ilasCnt_q == 2'(ILAS_MF - 1)) begin
							state_d = LINK_DATA;
						end
					end
				end
				LINK_DATA: state_d = LINK_DATA;
				default: state_d = LINK_CGS;
			endcase
			if (!handshakeLevel) begin
				state_d = LINK_CGS;
			end
		end
		// the waiting state holds commas until the multiframe edge after release
		octets_d = '0;
		isCtl_d = '0;
		active_d = '0;
		header_d = HDR_IDLE;
		blockStart_d = 1'b0;
		boundary_d = 1'b0;
		for (int l = 0; l < LANES_MAX; l++) begin
			if (LANE_CNT_W'(l) < lanesUsed) begin
				active_d[l] = 1'b1;
				case (state_q)
					LINK_CGS, LINK_WAIT_MF: begin
						octets_d[8*l +: 8] = CHAR_COMMA;
						isCtl_d[l] = 1'b1;
					end
					LINK_ILAS: begin
						octets_d[8*l +: 8] = ilasOct;
						isCtl_d[l] = ilasCtl;
					end
					default: octets_d[8*l +: 8] = stage_q[l];
				endcase
			end
		end
		if (state_q == LINK_BLOCKS) begin
			// payload-only blocks: data header, no CRC3 field, no command bits
			header_d = HDR_DATA;
			blockStart_d = (blkOct_q == 3'h0);
			boundary_d = blockStart_d && mbCnt_q == 5'h0 && embCnt_q == 2'h0;
		end else begin
			boundary_d = (mfCnt_q == 5'h0);
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= LINK_CGS;
			mfCnt_q <= 5'h0;
			ilasCnt_q <= 2'h0;
			blkOct_q <= 3'h0;
			mbCnt_q <= 5'h0;
			embCnt_q <= 2'h0;
			laneOctets <= '0;
			laneIsControl <= '0;
			laneActive <= '0;
			blockHeader <= HDR_IDLE;
			blockStart <= 1'b0;
			frameBoundary <= 1'b0;
			fecActive <= 1'b0;
			complexOutput <= 1'b0;
			linkUp <= 1'b0;
		end else begin
			state_q <= state_d;
			mfCnt_q <= mfCnt_d;
			ilasCnt_q <= ilasCnt_d;
			blkOct_q <= blkOct_d;
			mbCnt_q <= mbCnt_d;
			embCnt_q <= embCnt_d;
			laneOctets <= octets_d;
			laneIsControl <= isCtl_d;
			laneActive <= active_d;
			blockHeader <= header_d;
			blockStart <= blockStart_d;
			frameBoundary <= boundary_d;
			fecActive <= fecEnable & mode66;
			complexOutput <= (decSel != DEC_BYPASS) && (decSel <= DEC_BY32);
			linkUp <= (state_q == LINK_DATA) || (state_q == LINK_BLOCKS);
		end
	end

	assign ncoSyncPulse = ncoSync_q;
endmodule
`default_nettype wire

/* dv/ddc_link_chk.sv */
// port assertions for the serial link transmitter
`timescale 1ns/100ps
`default_nettype none
module ddc_link_chk
	import ddc_link_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ddc_link_pkg::MODE_W-1:0] linkModeSelect,
	input wire logic [ddc_link_pkg::LANE_CNT_W-1:0] laneCount,
	input wire logic fecEnable,
	input wire logic handshakeUsePair,
	input wire logic handshakeSingleEndedIn,
	input wire logic sysrefIn,
	input wire logic [8*ddc_link_pkg::LANES_MAX-1:0] laneOctets,
	input wire logic [ddc_link_pkg::LANES_MAX-1:0] laneIsControl,
	input wire logic [ddc_link_pkg::LANES_MAX-1:0] laneActive,
	input wire logic [1:0] blockHeader,
	input wire logic blockStart,
	input wire logic frameBoundary,
	input wire logic ncoSyncPulse,
	input wire logic fecActive,
	input wire logic complexOutput
);
	logic [15:0] expMask;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	always_comb begin
		int n;
		n = (laneCount == 5'h00) ? 1 : ((laneCount > 5'h10) ? 16 : int'(laneCount));
		expMask = 16'hFFFF >> (16 - n);
	end
	chk_comma_request: assert property (
		(!handshakeUsePair && !linkModeSelect[3] && !handshakeSingleEndedIn)[*6]
		|-> laneOctets[7:0] == CHAR_COMMA && laneIsControl[0]) else $error("no comma while requested");
	chk_header_data: assert property (linkModeSelect[3][*4] |-> blockHeader == HDR_DATA)
		else $error("block header missing");
	chk_header_idle: assert property ((!linkModeSelect[3])[*4] |-> blockHeader == HDR_IDLE && !blockStart)
		else $error("block framing in 8b10b");
	chk_fec_gate: assert property ($past(nrst) |-> fecActive == $past(fecEnable && linkModeSelect[3]))
		else $error("fec state wrong");
	chk_nco_single: assert property (ncoSyncPulse |-> linkModeSelect[3] ##1 !ncoSyncPulse)
		else $error("nco pulse wrong");
	chk_nco_trigger: assert property (
		$fell(handshakeSingleEndedIn) && linkModeSelect[3] && !handshakeUsePair |-> ##[2:5] ncoSyncPulse)
		else $error("nco pulse missing");
	chk_block_period: assert property (
		(linkModeSelect[3] && !sysrefIn)[*8] ##0 blockStart ##1 (linkModeSelect[3] && !sysrefIn)[*7]
		|=> blockStart) else $error("block period not 8");
	chk_sysref_frame: assert property ($rose(sysrefIn) |-> ##[3:5] frameBoundary)
		else $error("sysref did not realign");
	chk_lane_mask: assert property ($past(nrst) |-> laneActive == $past(expMask))
		else $error("lane mask wrong");
	chk_complex_mode: assert property (
		$past(nrst) |-> complexOutput == ($past(linkModeSelect[2:0]) inside {[3'h1:3'h4]}))
		else $error("complex flag wrong");
endmodule
bind ddc_to_serial_link_tx ddc_link_chk i_ddc_link_chk (.clk, .nrst, .linkModeSelect, .laneCount, .fecEnable,
	.handshakeUsePair, .handshakeSingleEndedIn, .sysrefIn, .laneOctets, .laneIsControl, .laneActive,
	.blockHeader, .blockStart, .frameBoundary, .ncoSyncPulse, .fecActive, .complexOutput);
`default_nettype wire

/* dv/link_rx_model.sv */
// receiving logic model: requests the link and releases it after commas
`timescale 1ns/100ps
`default_nettype none
module link_rx_model
	import ddc_link_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic forceLow,
	input wire logic [7:0] lane0Octet,
	input wire logic lane0IsControl,
	input wire logic frameBoundary,
	output logic handshakeN
);
	logic [2:0] commaCnt;
	// runs on the falling edge so requests change off the transmitter's sampling edge
	always_ff @(negedge clk or negedge nrst) begin
		if (!nrst) begin
			handshakeN <= 1'b0;
			commaCnt <= 3'h0;
		end else if (forceLow) begin
			handshakeN <= 1'b0;
			commaCnt <= 3'h0;
		end else if (!handshakeN) begin
			if (lane0Octet == CHAR_COMMA && lane0IsControl)
				commaCnt <= (commaCnt == 3'h4) ? 3'h4 : commaCnt + 3'h1;
			else
				commaCnt <= 3'h0;
			if (commaCnt == 3'h4 && frameBoundary)
				handshakeN <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* dv/ddc_to_serial_link_tx_tb.sv */
// self-checking bench for the serial link transmitter
`timescale 1ns/100ps
`default_nettype none
module ddc_to_serial_link_tx_tb;
	import ddc_link_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [MODE_W-1:0] linkModeSelect = 4'h0;
	logic gainBoost = 1'b0;
	logic [LANE_CNT_W-1:0] laneCount = 5'h04;
	logic fecEnable = 1'b0;
	logic handshakeUsePair = 1'b0;
	logic timestampPairPos = 1'b1;
	logic timestampPairNeg = 1'b0;
	logic sysrefIn = 1'b0;
	logic signed [SAMPLE_W-1:0] sampleIn = 12'h000;
	logic forceLow = 1'b1;
	wire logic handshakeN;
	logic [8*LANES_MAX-1:0] laneOctets;
	logic [LANES_MAX-1:0] laneIsControl;
	logic [LANES_MAX-1:0] laneActive;
	logic [1:0] blockHeader;
	logic blockStart, frameBoundary, ncoSyncPulse, fecActive, complexOutput, linkUp;
	int errors = 0;
	int n_compared = 0;
	always #2.5 clk = ~clk;
	ddc_to_serial_link_tx i_ddc_to_serial_link_tx (.clk, .nrst, .linkModeSelect, .gainBoost, .laneCount,
		.fecEnable, .handshakeUsePair, .handshakeSingleEndedIn(handshakeN), .timestampPairPos,
		.timestampPairNeg, .sysrefIn, .sampleIn, .laneOctets, .laneIsControl, .laneActive, .blockHeader,
		.blockStart, .frameBoundary, .ncoSyncPulse, .fecActive, .complexOutput, .linkUp);
	link_rx_model i_link_rx_model (.clk, .nrst, .forceLow, .lane0Octet(laneOctets[7:0]),
		.lane0IsControl(laneIsControl[0]), .frameBoundary, .handshakeN);
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic expire(input string what);
		errors++;
		$display("CHECK FAILED %s exp done seen timeout", what);
		tally_and_finish();
	endtask
	task automatic test_link8;
		int i;
		int ends;
		int rel;
		cyc(20);
		check("comma", {laneIsControl[0], laneOctets[7:0]}, 16'h01BC);
		check("active", laneActive, 16'h000F);
		forceLow <= 1'b0;
		rel = 0;
		for (i = 0; i < 200 && laneOctets[7:0] == CHAR_COMMA; i++) begin
			rel += int'(handshakeN === 1'b1);
			cyc(1);
		end
		if (i == 200)
			expire("ilas");
		check("ilasStart", {laneIsControl[0], laneOctets[7:0]}, 16'h011C);
		// alignment must start on the first multiframe edge after the release, not a later one
		check("ilasDelay", 16'(rel > 0 && rel < 40), 16'h0001);
		ends = 0;
		for (i = 0; i < 300 && !linkUp; i++) begin
			if (laneIsControl[0] && laneOctets[7:0] == CHAR_MF_END)
				ends++;
			cyc(1);
		end
		if (i == 300)
			expire("linkUp");
		check("ilasEnds", 16'(ends), 16'h0004);
	endtask
	task automatic boost_case(input logic [11:0] s, input logic b, input logic [15:0] w);
		sampleIn = s;
		gainBoost = b;
		cyc(8);
		check("laneWord", {laneOctets[7:0], laneOctets[15:8]}, w);
	endtask
	task automatic test_boost;
		laneCount = 5'h02;
		boost_case(12'h7FF, 1'b0, 16'h7FF0);
		boost_case(12'h7FF, 1'b1, 16'h7FFF);
		boost_case(12'h800, 1'b1, 16'h8000);
		boost_case(12'h100, 1'b1, 16'h2000);
		boost_case(12'h800, 1'b0, 16'h8000);
		gainBoost = 1'b0;
	endtask
	task automatic test_pair;
		int i;
		handshakeUsePair = 1'b1;
		cyc(10);
		check("pairHigh", 16'(linkUp), 16'h0001);
		timestampPairPos = 1'b0;
		cyc(10);
		check("pairLow", {laneIsControl[0], laneOctets[7:0]}, 16'h01BC);
		handshakeUsePair = 1'b0;
		timestampPairPos = 1'b1;
		for (i = 0; i < 300 && linkUp !== 1'b1; i++)
			cyc(1);
		check("relink", 16'(linkUp), 16'h0001);
	endtask
	task automatic test_modes;
		int d;
		for (d = 0; d < 5; d++) begin
			linkModeSelect = 4'(d);
			cyc(3);
			check("complex", 16'(complexOutput), 16'(d != 0));
		end
		// fs/4 mixing cancels a constant input, so every complex word settles to zero
		cyc(80);
		check("dcLow", laneOctets[15:0], 16'h0000);
		check("dcHigh", laneOctets[31:16], 16'h0000);
		laneCount = 5'h00;
		cyc(2);
		check("lanesMin", laneActive, 16'h0001);
		laneCount = 5'h11;
		cyc(2);
		check("lanesMax", laneActive, 16'hFFFF);
	endtask
	task automatic test_66;
		int k;
		int nco;
		int bs;
		linkModeSelect = 4'h8;
		fecEnable = 1'b1;
		cyc(10);
		check("header", 16'(blockHeader), 16'h0001);
		check("fec", 16'(fecActive), 16'h0001);
		forceLow <= 1'b1;
		nco = 0;
		bs = 0;
		for (k = 0; k < 64; k++) begin
			nco += int'(ncoSyncPulse);
			bs += int'(blockStart);
			cyc(1);
		end
		check("nco", 16'(nco), 16'h0001);
		check("blocks", 16'(bs), 16'h0008);
		check("up66", 16'(linkUp), 16'h0001);
		sysrefIn = 1'b1;
		for (k = 0; k < 8 && frameBoundary !== 1'b1; k++)
			cyc(1);
		check("sysref", 16'(k < 8), 16'h0001);
		sysrefIn = 1'b0;
		linkModeSelect = 4'h0;
		cyc(3);
		check("fecOff", 16'(fecActive), 16'h0000);
	endtask
	initial begin
		cyc(6);
		nrst = 1'b1;
		test_link8();
		test_boost();
		test_pair();
		test_modes();
		test_66();
		tally_and_finish();
	end
endmodule
`default_nettype wire
